// ===== taee_exception_unit.sv
// Trace, address error and interrupt entry sequencing with module-stop registers
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "taee_defines.svh"

module taee_exception_unit #(
  parameter int NUM_DMA_CH = 4
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // AHB-Lite register slave
  input  wire logic                  hsel,
  input  wire logic [11:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Peripheral register access gate
  input  wire logic                  periph_acc_req,
  input  wire logic [5:0]            periph_acc_index,
  output logic                       periph_acc_grant,
  output logic [47:0]                module_stop,
  // Core instruction sequencer
  input  wire logic                  instr_done,
  input  wire logic                  instr_is_return,
  input  wire logic [31:0]           stack_pointer,
  input  wire taee_pkg::taee_status_s status_in,
  output taee_pkg::taee_status_s     status_out,
  output logic                       status_load,
  output logic                       push_pc_req,
  output logic                       push_status_req,
  output logic                       vector_fetch_req,
  output logic [31:0]                vector_addr,
  input  wire logic                  step_ack,
  output logic                       handler_start,
  output logic                       entry_busy,
  output logic                       stack_undefined,
  // Bus controller
  input  wire taee_pkg::taee_cycle_s cycle_in,
  input  wire logic                  single_chip_mode,
  // DMA controller
  output logic                       dma_error_flag_set,
  output logic [NUM_DMA_CH-1:0]      dma_transfer_enable_clr,
  // Interrupt sources
  input  wire logic                  nmi_pin,
  input  wire logic [15:0]           external_irq_pins,
  input  wire logic                  periph_irq_req,
  input  wire logic [7:0]            periph_irq_vector,
  output logic                       intr_taken
);
  import taee_pkg::*;

  if (NUM_DMA_CH < 1 || NUM_DMA_CH > 8) begin : g_bad_ch
    $error("NUM_DMA_CH must lie between 1 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic        rst_meta;
  logic        rst_n;
  logic [16:0] pin_meta;
  logic [16:0] pin_sync;
  logic        nmi_prev;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 17'h0_0000;
      pin_sync <= 17'h0_0000;
      nmi_prev <= 1'b0;
    end else begin
      pin_meta <= {nmi_pin, external_irq_pins};
      pin_sync <= pin_meta;
      nmi_prev <= pin_sync[16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [15:0] module_stop_ctrl_a;
  logic [15:0] module_stop_ctrl_b;
  logic [15:0] module_stop_ctrl_c;
  logic [1:0]  intr_mode;
  logic [31:0] vector_base_reg;
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic        addr_phase;
  logic        mode2;
  logic        sticky_aerr;
  logic        sticky_dma;

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];
  assign mode2      = (intr_mode == TAEE_MODE2);
  assign module_stop = {module_stop_ctrl_c, module_stop_ctrl_b, module_stop_ctrl_a};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr;
    end
  end

  // Write data arrives one cycle after its address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_stop_ctrl_a <= `TAEE_RST_MSTOP_A;
      module_stop_ctrl_b <= `TAEE_RST_MSTOP_B;
      module_stop_ctrl_c <= `TAEE_RST_MSTOP_C;
      intr_mode          <= TAEE_MODE0;
      vector_base_reg    <= `TAEE_RST_VEC_BASE;
    end else if (wr_pend) begin
      unique case (wr_addr)
        `TAEE_OFF_MSTOP_A: module_stop_ctrl_a <= hwdata[15:0];
        `TAEE_OFF_MSTOP_B: module_stop_ctrl_b <= hwdata[15:0];
        `TAEE_OFF_MSTOP_C: module_stop_ctrl_c <= hwdata[15:0];
        // Only codes 0 and 2 are kept; others leave the mode alone
        `TAEE_OFF_MODE: begin
          if (hwdata[`TAEE_MODE_MSB:`TAEE_MODE_LSB] == TAEE_MODE0 ||
              hwdata[`TAEE_MODE_MSB:`TAEE_MODE_LSB] == TAEE_MODE2) begin
            intr_mode <= hwdata[`TAEE_MODE_MSB:`TAEE_MODE_LSB];
          end
        end
        `TAEE_OFF_VEC_BASE: vector_base_reg <= hwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr)
        `TAEE_OFF_MSTOP_A: hrdata <= {16'h0000, module_stop_ctrl_a};
        `TAEE_OFF_MSTOP_B: hrdata <= {16'h0000, module_stop_ctrl_b};
        `TAEE_OFF_MSTOP_C: hrdata <= {16'h0000, module_stop_ctrl_c};
        `TAEE_OFF_MODE:    hrdata <= {26'h000_0000, intr_mode, 4'h0};
        `TAEE_OFF_STATUS:  hrdata <= {27'h000_0000, stack_undefined, sticky_dma,
                                      sticky_aerr, entry_busy, mode2};
        `TAEE_OFF_VEC_BASE: hrdata <= vector_base_reg;
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // A set stop bit refuses the access outright
  assign periph_acc_grant = periph_acc_req && !module_stop[periph_acc_index];

  ////////////////////////////////////////////////////////////////////////////
  // Address error detection

  logic        entry_active;
  logic        aerr_hit;
  logic        aerr_pend;
  logic        aerr_pend_dma;
  logic        ext_bad;

  assign ext_bad = (cycle_in.in_external && single_chip_mode) || cycle_in.prohibited;

  always_comb begin
    aerr_hit = 1'b0;
    unique case (cycle_in.kind)
      TAEE_CYC_FETCH: aerr_hit = cycle_in.addr[0] || cycle_in.in_periph || ext_bad;
      TAEE_CYC_STACK: aerr_hit = cycle_in.addr[0];
      TAEE_CYC_DATA:  aerr_hit = ext_bad;
      TAEE_CYC_SINGLE: aerr_hit = !cycle_in.in_external;
    endcase
    // Stacking of an entry must not start a fresh entry
    aerr_hit = aerr_hit && cycle_in.done && !entry_active;
  end

  // Halting the DMA is immediate, not deferred to entry
  assign dma_error_flag_set      = aerr_hit;
  assign dma_transfer_enable_clr = {NUM_DMA_CH{aerr_hit}};

  ////////////////////////////////////////////////////////////////////////////
  // Entry sequencer

  taee_state_e state;
  taee_src_e   src;
  logic        trace_due;
  logic        nmi_edge;
  logic [15:0] irq_live;
  logic        irq_due;
  logic [7:0]  irq_vec;
  logic        start_now;
  logic        nmi_pend;
  logic [31:0] next_vector_addr;
  logic [31:0] irq_vec_q;

  function automatic logic [31:0] vec_off(input logic [7:0] vec);
    return {22'h00_0000, vec, 2'b00};
  endfunction

  // Mask bits play no part here, only mode, trace enable and the return flag
  assign trace_due = instr_done && mode2 && status_in.trace_en
                     && !instr_is_return;
  assign nmi_edge  = pin_sync[16] && !nmi_prev;
  // Maskable sources blocked by the mask only in mode 0; priority masking lives elsewhere
  assign irq_live  = pin_sync[15:0] & {16{mode2 || !status_in.int_mask}};

  always_comb begin
    irq_due = 1'b1;
    irq_vec = 8'h00;
    if (nmi_pend) begin
      irq_vec = 8'(`TAEE_VOFF_NMI >> `TAEE_VEC_SHIFT);
    end else if (irq_live != 16'h0000) begin
      irq_vec = `TAEE_VEC_IRQ_BASE;
      for (int n = 15; n >= 0; n--) begin
        if (irq_live[n]) begin
          irq_vec = `TAEE_VEC_IRQ_BASE + 8'(n);
        end
      end
    end else if (periph_irq_req && (mode2 || !status_in.int_mask)) begin
      irq_vec = periph_irq_vector;
    end else begin
      irq_due = 1'b0;
    end
  end

  // Exceptions are taken only at an instruction boundary
  assign start_now = (state == TAEE_ST_IDLE) && instr_done
                     && (aerr_pend || aerr_hit || trace_due || irq_due);

  // Edge lasts one cycle; keep it until a boundary takes it, a new edge wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (start_now && !(aerr_pend || aerr_hit) && !trace_due) begin
      nmi_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aerr_pend     <= 1'b0;
      aerr_pend_dma <= 1'b0;
    end else if (start_now) begin
      aerr_pend     <= 1'b0;
      aerr_pend_dma <= 1'b0;
    end else if (aerr_hit) begin
      aerr_pend     <= 1'b1;
      aerr_pend_dma <= cycle_in.by_dma;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src <= TAEE_SRC_INTR;
    end else if (start_now) begin
      if (aerr_pend || aerr_hit) begin
        src <= (aerr_pend ? aerr_pend_dma : cycle_in.by_dma) ? TAEE_SRC_DMA_AERR
                                                             : TAEE_SRC_CPU_AERR;
      end else if (trace_due) begin
        src <= TAEE_SRC_TRACE;
      end else begin
        src <= TAEE_SRC_INTR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TAEE_ST_IDLE;
    end else begin
      unique case (state)
        TAEE_ST_IDLE:    if (start_now) state <= TAEE_ST_PUSH_PC;
        TAEE_ST_PUSH_PC: if (step_ack) state <= TAEE_ST_PUSH_ST;
        TAEE_ST_PUSH_ST: if (step_ack) state <= TAEE_ST_UPDATE;
        TAEE_ST_UPDATE:  state <= TAEE_ST_VEC;
        TAEE_ST_VEC:     if (step_ack) state <= TAEE_ST_GO;
        TAEE_ST_GO:      state <= TAEE_ST_IDLE;
        default:         state <= TAEE_ST_IDLE;
      endcase
    end
  end

  assign entry_active     = (state != TAEE_ST_IDLE);
  assign entry_busy       = entry_active;
  assign push_pc_req      = (state == TAEE_ST_PUSH_PC);
  assign push_status_req  = (state == TAEE_ST_PUSH_ST);
  assign vector_fetch_req = (state == TAEE_ST_VEC);
  assign handler_start    = (state == TAEE_ST_GO);
  assign status_load      = (state == TAEE_ST_UPDATE);
  assign intr_taken       = handler_start && (src == TAEE_SRC_INTR);

  // New status: mask set; in mode 2 trace bit cleared and error forces priority 7
  always_comb begin
    status_out          = status_in;
    status_out.int_mask = 1'b1;
    if (mode2) begin
      status_out.trace_en = 1'b0;
      if (src == TAEE_SRC_CPU_AERR || src == TAEE_SRC_DMA_AERR) begin
        status_out.priority_mask_field = `TAEE_PRIO_ALL;
      end
    end
  end

  always_comb begin
    unique case (src)
      TAEE_SRC_CPU_AERR: next_vector_addr = `TAEE_VOFF_CPU_AERR;
      TAEE_SRC_DMA_AERR: next_vector_addr = vector_base_reg + `TAEE_VOFF_DMA_AERR;
      TAEE_SRC_TRACE:    next_vector_addr = vector_base_reg + `TAEE_VOFF_TRACE;
      TAEE_SRC_INTR:     next_vector_addr = vector_base_reg + irq_vec_q;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_vec_q   <= 32'h0000_0000;
      vector_addr <= 32'h0000_0000;
    end else begin
      if (start_now) begin
        irq_vec_q <= vec_off(irq_vec);
      end
      vector_addr <= next_vector_addr;
    end
  end

  // Stacked values cannot be trusted from an odd stack pointer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_undefined <= 1'b0;
    end else if (start_now) begin
      stack_undefined <= stack_pointer[0] && (aerr_pend || aerr_hit);
    end
  end

  // Sticky history for software, cleared by reading is not provided
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_aerr <= 1'b0;
      sticky_dma  <= 1'b0;
    end else if (aerr_hit) begin
      sticky_aerr <= 1'b1;
      sticky_dma  <= sticky_dma || cycle_in.by_dma;
    end else if (wr_pend && wr_addr == `TAEE_OFF_STATUS) begin
      sticky_aerr <= 1'b0;
      sticky_dma  <= 1'b0;
    end
  end

endmodule

// ===== taee_defines.svh
// Offsets, reset values, field positions and vector figures of the exception unit
`ifndef TAEE_DEFINES_SVH
`define TAEE_DEFINES_SVH

`define TAEE_OFF_MSTOP_A     12'h000
`define TAEE_OFF_MSTOP_B     12'h004
`define TAEE_OFF_MSTOP_C     12'h008
`define TAEE_OFF_MODE        12'h00c
`define TAEE_OFF_STATUS      12'h010
`define TAEE_OFF_VEC_BASE    12'h014

`define TAEE_RST_MSTOP_A     16'h0fff
`define TAEE_RST_MSTOP_B     16'hffff
`define TAEE_RST_MSTOP_C     16'hff00
`define TAEE_RST_VEC_BASE    32'h0000_0000

`define TAEE_MODE_LSB        4
`define TAEE_MODE_MSB        5

`define TAEE_PRIO_ALL        3'h7

`define TAEE_VOFF_TRACE      32'h0000_0014
`define TAEE_VOFF_NMI        32'h0000_001c
`define TAEE_VOFF_CPU_AERR   32'h0000_0030
`define TAEE_VOFF_DMA_AERR   32'h0000_0034
`define TAEE_VEC_IRQ_BASE    8'h40
`define TAEE_VEC_SHIFT       2

`endif

// ===== taee_pkg.sv
// Types shared by the exception unit and its neighbours
package taee_pkg;

  typedef enum logic [1:0] {
    TAEE_MODE0 = 2'b00,
    TAEE_MODE2 = 2'b10
  } taee_mode_e;

  typedef enum logic [1:0] {
    TAEE_CYC_FETCH  = 2'b00,
    TAEE_CYC_STACK  = 2'b01,
    TAEE_CYC_DATA   = 2'b10,
    TAEE_CYC_SINGLE = 2'b11
  } taee_cyc_e;

  typedef enum logic [1:0] {
    TAEE_SRC_CPU_AERR = 2'b00,
    TAEE_SRC_DMA_AERR = 2'b01,
    TAEE_SRC_TRACE    = 2'b10,
    TAEE_SRC_INTR     = 2'b11
  } taee_src_e;

  typedef enum logic [2:0] {
    TAEE_ST_IDLE     = 3'b000,
    TAEE_ST_PUSH_PC  = 3'b001,
    TAEE_ST_PUSH_ST  = 3'b010,
    TAEE_ST_UPDATE   = 3'b011,
    TAEE_ST_VEC      = 3'b100,
    TAEE_ST_GO       = 3'b101
  } taee_state_e;

  // One bus cycle as seen at its end, with region flags from the bus controller
  typedef struct packed {
    logic        done;
    logic        by_dma;
    taee_cyc_e   kind;
    logic [23:0] addr;
    logic        in_periph;
    logic        in_external;
    logic        prohibited;
  } taee_cycle_s;

  // Condition code and extended control state the core exchanges with the unit
  typedef struct packed {
    logic       int_mask;
    logic       user_mask_bit;
    logic       trace_en;
    logic [2:0] priority_mask_field;
  } taee_status_s;

endpackage

// ===== taee_exception_unit_props.sv
// Port-level assertions for the exception unit, bound to its top
`timescale 1ns/1ps
module taee_exception_unit_props
  import taee_pkg::*;
#(
  parameter int NUM_DMA_CH = 4
) (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  reset_n,
  // Peripheral gate
  input wire logic                  periph_acc_req,
  input wire logic [5:0]            periph_acc_index,
  input wire logic                  periph_acc_grant,
  input wire logic [47:0]           module_stop,
  // Core side
  input wire logic                  instr_done,
  input wire logic [31:0]           stack_pointer,
  input wire taee_pkg::taee_status_s status_in,
  input wire taee_pkg::taee_status_s status_out,
  input wire logic                  status_load,
  input wire logic                  push_pc_req,
  input wire logic                  push_status_req,
  input wire logic                  vector_fetch_req,
  input wire logic                  step_ack,
  input wire logic                  handler_start,
  input wire logic                  entry_busy,
  // Bus and DMA side
  input wire taee_pkg::taee_cycle_s cycle_in,
  input wire logic                  single_chip_mode,
  input wire logic                  dma_error_flag_set,
  input wire logic [NUM_DMA_CH-1:0] dma_transfer_enable_clr
);
  logic ext_bad;
  logic aerr;

  always_comb begin
    ext_bad = (cycle_in.in_external & single_chip_mode) | cycle_in.prohibited;
    case (cycle_in.kind)
      TAEE_CYC_FETCH: aerr = ext_bad | cycle_in.addr[0] | cycle_in.in_periph;
      TAEE_CYC_STACK: aerr = stack_pointer[0];
      TAEE_CYC_DATA:  aerr = ext_bad;
      default:        aerr = !cycle_in.in_external;
    endcase
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_stop: assert property ($rose(reset_n) |-> module_stop == 48'hff00_ffff_0fff)
    else $error("module stop not at reset value");
  a_grant_gate: assert property (
    periph_acc_grant == (periph_acc_req && !module_stop[periph_acc_index]))
    else $error("peripheral grant ignores module stop");
  a_err_halts_dma: assert property (
    cycle_in.done && aerr && !entry_busy |-> dma_error_flag_set && &dma_transfer_enable_clr)
    else $error("address error did not halt dma");
  a_clean_quiet: assert property (
    !(cycle_in.done && aerr) |-> !dma_error_flag_set && dma_transfer_enable_clr == '0)
    else $error("dma halted without address error");
  a_busy_ignores: assert property (entry_busy |-> !dma_error_flag_set)
    else $error("error accepted during entry");
  a_wait_instr: assert property ($rose(entry_busy) |-> $past(instr_done))
    else $error("entry began off an instruction boundary");
  a_mask_set: assert property (
    status_load |-> status_out.int_mask && status_out.user_mask_bit == status_in.user_mask_bit)
    else $error("entry status mask wrong");
  a_push_order: assert property (push_pc_req && step_ack |=> push_status_req)
    else $error("status push did not follow pc push");
  a_load_then_vec: assert property (
    push_status_req && step_ack |=> status_load ##1 vector_fetch_req)
    else $error("status update or vector fetch out of order");
  a_start_ends: assert property (
    vector_fetch_req && step_ack |=> handler_start ##1 !entry_busy)
    else $error("handler start or idle return missing");

  c_entry: cover property (handler_start);
  c_trace_clear: cover property (status_load && status_in.trace_en && !status_out.trace_en);
  c_busy_fault: cover property (entry_busy && cycle_in.done && aerr);
endmodule

bind taee_exception_unit taee_exception_unit_props #(.NUM_DMA_CH(NUM_DMA_CH)) u_props (.*);

// ===== taee_core_model.sv
// Core sequencer stand-in that acknowledges entry steps after a set delay
`timescale 1ns/1ps
module taee_core_model (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  // Entry steps from the unit
  input  wire logic                   push_pc_req,
  input  wire logic                   push_status_req,
  input  wire logic                   vector_fetch_req,
  input  wire logic                   status_load,
  input  wire taee_pkg::taee_status_s status_out,
  input  wire logic [31:0]            vector_addr,
  // Pacing and what the core took
  input  wire logic [1:0]             dly,
  output logic                        step_ack,
  output logic [31:0]                 vec_seen,
  output taee_pkg::taee_status_s      stat_seen
);
  import taee_pkg::*;
  logic [1:0] wait_cnt;
  wire        any_req = push_pc_req | push_status_req | vector_fetch_req;

  // Ack drops after each step so one level is never taken twice
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (any_req && !step_ack && wait_cnt >= dly) begin
      step_ack <= 1'b1;
      wait_cnt <= 2'h0;
    end else begin
      step_ack <= 1'b0;
      wait_cnt <= any_req ? wait_cnt + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (status_load) stat_seen <= status_out;
    if (vector_fetch_req && step_ack) vec_seen <= vector_addr;
  end
endmodule

// ===== trace_address_error_exceptions_tb.sv
// Random and corner-case bench for the trace and address error unit
`timescale 1ns/1ps
module trace_address_error_exceptions_tb;
  import taee_pkg::*;
  logic         core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic         instr_done = 1'b0, instr_is_return = 1'b0, single_chip_mode = 1'b0;
  logic         nmi_pin = 1'b0, periph_irq_req = 1'b0, periph_acc_req = 1'b0;
  logic [1:0]   htrans = 2'b00, dly = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [5:0]   periph_acc_index = 6'h00, idx;
  logic [7:0]   periph_irq_vector = 8'h00;
  logic [11:0]  haddr = 12'h000;
  logic [15:0]  external_irq_pins = 16'h0000;
  logic [31:0]  hwdata = 32'h0, stack_pointer = 32'h0, hrdata, vector_addr, vec_seen, q, vb, sp;
  logic         hready, hreadyout, hresp, periph_acc_grant, status_load, push_pc_req, scm;
  logic         push_status_req, vector_fetch_req, step_ack, handler_start, entry_busy, m2, e;
  logic         stack_undefined, dma_error_flag_set, intr_taken;
  logic [3:0]   dma_transfer_enable_clr;
  logic [47:0]  module_stop, stops = 48'hff00_ffff_0fff;
  taee_status_s status_in = '0, status_out, stat_seen, st;
  taee_cycle_s  cycle_in = '0, c;
  integer       seed = 32'h8bc5;
  int           miscompares = 0, n_checks = 0;

  assign hready = hreadyout;
  always #20 core_clk = ~core_clk;
  taee_exception_unit DUT (.*);
  taee_core_model     u_core (.*);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic timeout();
    chk(1'b0, 1'b1);
    summarize();
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr();
    int w;
    w = 0;
    do begin
      @(posedge core_clk);
      w++;
    end while (hready !== 1'b1 && w < 20);
    if (w >= 20) timeout();
  endtask

  // Address phase held until ready, then data phase until ready again
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wr();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wr();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask

  task automatic step(input logic ret);
    dly <= 2'($random(seed));
    instr_done <= 1'b1;
    instr_is_return <= ret;
    tk(1);
    instr_done <= 1'b0;
    instr_is_return <= 1'b0;
  endtask

  task automatic ee(input logic [31:0] ev, input taee_status_s es, input logic it);
    int w;
    w = 0;
    do begin
      @(negedge core_clk);
      w++;
    end while (handler_start !== 1'b1 && w < 60);
    if (w >= 60) timeout();
    chk(vec_seen, ev);
    chk(stat_seen, es);
    chk(intr_taken, it);
    tk(1);
  endtask

  task automatic en();
    repeat (4) begin
      @(negedge core_clk);
      chk(entry_busy, 1'b0);
    end
    tk(1);
  endtask

  function automatic logic xerr(taee_cycle_s x, logic s, logic [31:0] p);
    logic b;
    b = (x.in_external & s) | x.prohibited;
    case (x.kind)
      TAEE_CYC_FETCH: return b | x.addr[0] | x.in_periph;
      TAEE_CYC_STACK: return p[0];
      TAEE_CYC_DATA:  return b;
      default:        return !x.in_external;
    endcase
  endfunction

  function automatic taee_status_s xst(taee_status_s s, logic m, logic ae);
    xst = s;
    xst.int_mask = 1'b1;
    if (m) xst.trace_en = 1'b0;
    if (m && ae) xst.priority_mask_field = 3'h7;
  endfunction

  task automatic acase(input int i);
    c = 31'($random(seed));
    sp = $random(seed);
    scm = 1'($random(seed));
    c.done = 1'b1;
    c.kind = taee_cyc_e'(i[1:0]);
    c.by_dma = c.kind[1] & (c.kind[0] | c.by_dma);
    if (c.kind == TAEE_CYC_STACK) {c.in_periph, c.in_external, c.prohibited} = 3'b000;
    if (c.kind == TAEE_CYC_STACK) c.addr[0] = sp[0];
    e = xerr(c, scm, sp);
    cycle_in <= c;
    stack_pointer <= sp;
    single_chip_mode <= scm;
    #5;
    chk({dma_error_flag_set, dma_transfer_enable_clr}, {5{e}});
    tk(1);
    cycle_in.done <= 1'b0;
    step(1'b0);
    if (e) begin
      tk(1);
      cycle_in.done <= 1'b1;
      #5;
      chk(dma_error_flag_set, 1'b0);
      tk(1);
      cycle_in.done <= 1'b0;
      ee(c.by_dma ? vb + 32'h34 : 32'h30, xst(st, m2, 1'b1), 1'b0);
      chk(stack_undefined, sp[0]);
    end
    en();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    tk(3);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 12'(4 * i), 32'h0);
      chk(q, {16'h0, stops[16*i +: 16]});
    end
    bus(1'b0, 12'h0fc, 32'h0);
    chk(q, 32'h0);
    stops[15:0] = 16'($random(seed));
    bus(1'b1, 12'h000, {16'h0, stops[15:0]});
    periph_acc_req <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      idx = (i == 0) ? 6'd47 : 6'($unsigned($random(seed)) % 48);
      periph_acc_index <= idx;
      @(negedge core_clk);
      chk(periph_acc_grant, !stops[idx]);
      tk(1);
    end
    vb = $random(seed) & 32'hffff_fffc;
    bus(1'b1, 12'h014, vb);
    for (int m = 0; m < 2; m++) begin
      m2 = m[0];
      status_in.trace_en <= 1'b0;
      tk(1);
      bus(1'b1, 12'h00c, {26'h0, m2, 5'h0});
      st = 6'($random(seed));
      st.trace_en = !m2;
      status_in <= st;
      for (int i = 0; i < 16; i++) acase(i);
    end
    // Trace with the condition-code mask set, then return and resume
    st.trace_en = 1'b1;
    st.int_mask = 1'b1;
    status_in <= st;
    step(1'b0);
    ee(vb + 32'h14, xst(st, 1'b1, 1'b0), 1'b0);
    step(1'b1);
    en();
    step(1'b0);
    ee(vb + 32'h14, xst(st, 1'b1, 1'b0), 1'b0);
    st.trace_en = 1'b0;
    status_in <= st;
    for (int n = 0; n < 18; n++) begin
      periph_irq_vector <= 8'h50;
      periph_irq_req <= (n == 16);
      nmi_pin <= (n == 17);
      external_irq_pins <= 16'(17'h1 << n);
      tk(4);
      step(1'b0);
      ee(vb + (n == 17 ? 32'h1c : n == 16 ? 32'h140 : 32'(4 * (64 + n))),
         xst(st, 1'b1, 1'b0), 1'b1);
    end
    summarize();
  end
endmodule
